// *** include/pss_pkg.sv ***
// constants and carrier types for the power sequence supervisor host
package pss_pkg;

  localparam longint CLK_HZ = 64'd25_000_000;

  // times in their own units, figures as printed
  localparam longint SENSE_IGNORE_MS    = 64'd60;
  localparam longint PG_MIN_LOW_US      = 64'd4;
  localparam longint PG_MAX_LOW_MS      = 64'd1000;
  localparam longint SENSE_MIN_LOW_US   = 64'd500;
  localparam longint LOW_SUM_MAX_MS     = 64'd1050;
  localparam longint SENSE_HOLD_US      = 64'd500;
  localparam longint EXT_HOLD_MS        = 64'd20;
  localparam longint STANDBY_SHUTDOWN_S = 64'd123;

  // least times round up, longest times round down
  localparam longint SENSE_IGNORE_CYC =
    (SENSE_IGNORE_MS * CLK_HZ + 64'd999) / 64'd1000;
  localparam longint PG_MIN_LOW_CYC =
    (PG_MIN_LOW_US * CLK_HZ + 64'd999_999) / 64'd1_000_000;
  localparam longint PG_MAX_LOW_CYC = (PG_MAX_LOW_MS * CLK_HZ) / 64'd1000;
  localparam longint SENSE_MIN_LOW_CYC =
    (SENSE_MIN_LOW_US * CLK_HZ + 64'd999_999) / 64'd1_000_000;
  localparam longint LOW_SUM_MAX_CYC = (LOW_SUM_MAX_MS * CLK_HZ) / 64'd1000;
  localparam longint SENSE_HOLD_CYC =
    (SENSE_HOLD_US * CLK_HZ + 64'd999_999) / 64'd1_000_000;
  localparam longint EXT_HOLD_CYC =
    (EXT_HOLD_MS * CLK_HZ + 64'd999) / 64'd1000;
  localparam longint STANDBY_SHUTDOWN_CYC = STANDBY_SHUTDOWN_S * CLK_HZ;

  localparam int          CNT_W        = 32;
  localparam int          MODE_W       = 8;
  localparam logic [7:0]  MODE_STANDBY = 8'h01;

  typedef struct packed {
    logic sense;        // power_on_sense_in of the device
    logic supply_good;  // supply_good_in of the device
  } pss_pins_type;

  typedef struct packed {
    logic              valid;
    logic [MODE_W-1:0] mode;
  } pss_cmd_type;

endpackage

// *** logic/pss_timer.sv ***
// saturating up-counter with a threshold compare
`timescale 1ns/1ns
module pss_timer #(
  parameter int unsigned CNT_W = 32
) (
  input  wire logic             i_clk,
  input  wire logic             i_srst,
  input  wire logic             i_clear,
  input  wire logic [CNT_W-1:0] i_limit,
  output logic      [CNT_W-1:0] o_count,
  output logic                  o_done
);

  logic [CNT_W-1:0] count_q;

  // saturation keeps a long wait from wrapping back under its limit
  always_ff @(posedge i_clk) begin
    if (i_srst || i_clear) begin
      count_q <= '0;
    end else if (count_q != {CNT_W{1'b1}}) begin
      count_q <= count_q + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  assign o_count = count_q;
  assign o_done  = (count_q >= i_limit);

endmodule // pss_timer

// *** logic/pss_host_ctrl.sv ***
// host side supervisor: voltage monitor outputs and standby command
//
// Notes on behaviour
// - raise power-on-sense only once all rails reach 90% of minimum
// - once supply-good drops it stays low at least 4 us
// - with 1.8 V on, supply-good low no longer than 1000 ms (code only flags this on o_low_overrun)
// - power-on-sense low at least 500 us, at most 1000 ms with 1.8 V on (maximum only flagged on o_low_overrun)
// - with 1.8 V on, both low times together at most 1050 ms (code only flags this on o_low_overrun)
// - power-on-sense stays high 500 us after supply-good drops
// - supplies stay in regulation 20 ms after supply-good drops
// - planned shutdown sends power-mode standby (value 1) before power off
// - power not removed until 123 s after the standby command
// - planned shutdowns use the command, never supply-good as warning
`timescale 1ns/1ns
module pss_host_ctrl #(
  parameter int unsigned SENSE_IGNORE_CYC  = 32'(pss_pkg::SENSE_IGNORE_CYC),
  parameter int unsigned PG_MAX_LOW_CYC    = 32'(pss_pkg::PG_MAX_LOW_CYC),
  parameter int unsigned SENSE_MIN_LOW_CYC = 32'(pss_pkg::SENSE_MIN_LOW_CYC),
  parameter int unsigned LOW_SUM_MAX_CYC   = 32'(pss_pkg::LOW_SUM_MAX_CYC),
  parameter int unsigned SENSE_HOLD_CYC    = 32'(pss_pkg::SENSE_HOLD_CYC),
  parameter int unsigned EXT_HOLD_CYC      = 32'(pss_pkg::EXT_HOLD_CYC),
  parameter int unsigned STANDBY_CYC =
    32'(pss_pkg::STANDBY_SHUTDOWN_CYC)
) (
  input  wire logic                 i_clk,
  input  wire logic                 i_srst,
  input  wire logic                 i_rails_ok,
  input  wire logic                 i_v18_on,
  input  wire logic                 i_power_fail,
  input  wire logic                 i_shutdown_req,
  input  wire logic                 i_cmd_ready,
  output pss_pkg::pss_pins_type     o_pins,
  output pss_pkg::pss_cmd_type      o_cmd,
  output logic                      o_hold_supplies,
  output logic                      o_power_off_ok,
  output logic                      o_low_overrun
);

  localparam int W = pss_pkg::CNT_W;
  localparam logic [W-1:0] PG_MIN_LOW = W'(pss_pkg::PG_MIN_LOW_CYC);

  typedef enum logic [2:0] {
    ST_OFF, ST_SENSE, ST_RUN, ST_CMD, ST_STBY, ST_DROP, ST_DONE
  } pss_state_type;

  pss_state_type        state_q;
  pss_pkg::pss_pins_type pins_q;
  pss_pkg::pss_cmd_type  cmd_q;
  logic                 hold_q;
  logic                 off_ok_q;
  logic                 planned_q;
  logic                 overrun_q;
  logic [2:0]           rails_s_q;
  logic [2:0]           v18_s_q;
  logic [2:0]           fail_s_q;
  logic                 rails_ok;
  logic                 v18_on;
  logic                 fail;
  logic [W-1:0]         pg_low_cnt;
  logic [W-1:0]         sense_low_cnt;
  logic [W-1:0]         sense_hi_cnt;
  logic [W-1:0]         stby_cnt;
  logic                 pg_min_done;
  logic                 sense_low_done;
  logic                 sense_hi_done;
  logic                 stby_done;
  logic [W:0]           low_sum;

  // pins from the rail monitors: two flops before use, bit 2 unused spare
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      rails_s_q <= 3'h0;
      v18_s_q   <= 3'h0;
      fail_s_q  <= 3'h0;
    end else begin
      rails_s_q <= {1'b0, rails_s_q[0], i_rails_ok};
      v18_s_q   <= {1'b0, v18_s_q[0], i_v18_on};
      fail_s_q  <= {1'b0, fail_s_q[0], i_power_fail};
    end
  end

  assign rails_ok = rails_s_q[1];
  assign v18_on   = v18_s_q[1];
  assign fail     = fail_s_q[1];

  pss_timer #(.CNT_W(W)) u_pg_low (
    .i_clk   (i_clk),
    .i_srst  (i_srst),
    .i_clear (pins_q.supply_good),
    .i_limit (PG_MIN_LOW),
    .o_count (pg_low_cnt),
    .o_done  (pg_min_done)
  );

  pss_timer #(.CNT_W(W)) u_sense_low (
    .i_clk   (i_clk),
    .i_srst  (i_srst),
    .i_clear (pins_q.sense),
    .i_limit (W'(SENSE_MIN_LOW_CYC)),
    .o_count (sense_low_cnt),
    .o_done  (sense_low_done)
  );

  pss_timer #(.CNT_W(W)) u_sense_hi (
    .i_clk   (i_clk),
    .i_srst  (i_srst),
    .i_clear (!pins_q.sense),
    .i_limit (W'(SENSE_IGNORE_CYC)),
    .o_count (sense_hi_cnt),
    .o_done  (sense_hi_done)
  );

  pss_timer #(.CNT_W(W)) u_stby (
    .i_clk   (i_clk),
    .i_srst  (i_srst),
    .i_clear (state_q != ST_STBY),
    .i_limit (W'(STANDBY_CYC)),
    .o_count (stby_cnt),
    .o_done  (stby_done)
  );

  // sequencing: a power failure in any state from ST_SENSE to ST_STBY short-cuts to the drop state
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state_q   <= ST_OFF;
      pins_q    <= '0;
      cmd_q     <= '0;
      hold_q    <= 1'b1;
      off_ok_q  <= 1'b0;
      planned_q <= 1'b0;
    end else begin
      case (state_q)
        ST_OFF: begin
          // sense waits for good rails and a full minimum low time
          if (rails_ok && sense_low_done && !fail) begin
            pins_q.sense <= 1'b1;
            state_q      <= ST_SENSE;
          end
        end
        ST_SENSE: begin
          if (fail || !rails_ok) begin
            state_q <= ST_DROP;
          end else if (sense_hi_done && pg_min_done) begin
            // device comes out of reset on this edge
            pins_q.supply_good <= 1'b1;
            state_q            <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (fail) begin
            pins_q.supply_good <= 1'b0;
            planned_q          <= 1'b0;
            state_q            <= ST_DROP;
          end else if (i_shutdown_req) begin
            cmd_q.valid <= 1'b1;
            cmd_q.mode  <= pss_pkg::MODE_STANDBY;
            planned_q   <= 1'b1;
            state_q     <= ST_CMD;
          end
        end
        ST_CMD: begin
          if (i_cmd_ready) begin
            cmd_q.valid <= 1'b0;
          end
          if (fail) begin
            pins_q.supply_good <= 1'b0;
            cmd_q.valid        <= 1'b0;
            state_q            <= ST_DROP;
          end else if (i_cmd_ready) begin
            state_q <= ST_STBY;
          end
        end
        ST_STBY: begin
          // device parks the mirrors on its own during this wait
          if (fail || stby_done) begin
            pins_q.supply_good <= 1'b0;
            state_q            <= ST_DROP;
          end
        end
        ST_DROP: begin
          pins_q.supply_good <= 1'b0;
          if (pg_low_cnt >= W'(SENSE_HOLD_CYC)) begin
            pins_q.sense <= 1'b0;
          end
          // regulators are kept up until the park has had its time
          if (pg_low_cnt >= W'(EXT_HOLD_CYC) &&
              !pins_q.sense) begin
            hold_q   <= 1'b0;
            off_ok_q <= 1'b1;
            state_q  <= ST_DONE;
          end
        end
        ST_DONE: begin
          // restart only after the rails have really gone away
          if (!rails_ok) begin
            hold_q    <= 1'b1;
            off_ok_q  <= 1'b0;
            planned_q <= 1'b0;
            state_q   <= ST_OFF;
          end
        end
        default: begin
          state_q <= ST_OFF;
        end
      endcase
    end
  end

  // watchdog on low times; only meaningful while 1.8 V is up
  assign low_sum = {1'b0, pg_low_cnt} + {1'b0, sense_low_cnt};

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      overrun_q <= 1'b0;
    end else begin
      overrun_q <= v18_on && !pins_q.supply_good &&
                   ((pg_low_cnt > W'(PG_MAX_LOW_CYC)) ||
                    (!pins_q.sense &&
                     sense_low_cnt > W'(PG_MAX_LOW_CYC)) ||
                    (low_sum > (W+1)'(LOW_SUM_MAX_CYC)));
    end
  end

  assign o_pins          = pins_q;
  assign o_cmd           = cmd_q;
  assign o_hold_supplies = hold_q;
  assign o_power_off_ok  = off_ok_q;
  assign o_low_overrun   = overrun_q;

  sense_gate_a: assert property (@(posedge i_clk) disable iff (i_srst)
    $rose(pins_q.sense) |-> $past(rails_ok) && !$past(fail))
    else $error("sense raised without good rails");

  pg_ignore_a: assert property (@(posedge i_clk) disable iff (i_srst)
    $rose(pins_q.supply_good) |->
      pins_q.sense && sense_hi_cnt > W'(SENSE_IGNORE_CYC))
    else $error("supply good raised inside the ignore window");

  pg_min_low_a: assert property (@(posedge i_clk) disable iff (i_srst)
    $rose(pins_q.supply_good) |->
      $past(pg_low_cnt) >= PG_MIN_LOW)
    else $error("supply good low pulse too short");

  sense_min_low_a: assert property (@(posedge i_clk) disable iff (i_srst)
    $rose(pins_q.sense) |->
      $past(sense_low_cnt) >= W'(SENSE_MIN_LOW_CYC))
    else $error("sense low pulse too short");

  sense_hold_a: assert property (@(posedge i_clk) disable iff (i_srst)
    $fell(pins_q.sense) |->
      !pins_q.supply_good && pg_low_cnt > W'(SENSE_HOLD_CYC))
    else $error("sense dropped too soon after supply good");

  supply_hold_a: assert property (@(posedge i_clk) disable iff (i_srst)
    $fell(hold_q) |->
      pg_low_cnt > W'(EXT_HOLD_CYC) && o_power_off_ok)
    else $error("supplies released before extended hold");

  fail_drop_a: assert property (@(posedge i_clk) disable iff (i_srst)
    (state_q == ST_RUN && fail) |=> !pins_q.supply_good ##1
      (state_q == ST_DROP)[*2])
    else $error("power fail did not drop supply good");

  cmd_mode_a: assert property (@(posedge i_clk) disable iff (i_srst)
    (state_q == ST_RUN && i_shutdown_req && !fail) |=>
      cmd_q.valid && cmd_q.mode == pss_pkg::MODE_STANDBY)
    else $error("standby command not issued");

  cmd_stable_a: assert property (@(posedge i_clk) disable iff (i_srst)
    (cmd_q.valid && !i_cmd_ready && !fail) |=> cmd_q.valid)
    else $error("command withdrawn before accepted");

  standby_wait_a: assert property (@(posedge i_clk) disable iff (i_srst)
    ($fell(pins_q.supply_good) && planned_q && !$past(fail)) |->
      $past(stby_cnt) >= W'(STANDBY_CYC))
    else $error("planned power removal before standby time");

endmodule // pss_host_ctrl

// *** testbench/pss_dev_model.sv ***
// behavioural model of the supervised controller: reset, command, park
`timescale 1ns/1ns
module pss_dev_model #(
  parameter int IGNORE_CYC = 200,
  parameter int LOADS      = 8
) (
  input  wire logic             i_clk,
  input  pss_pkg::pss_pins_type i_pins,
  input  pss_pkg::pss_cmd_type  i_cmd,
  output logic                  o_cmd_ready,
  output logic                  o_in_reset,
  output logic                  o_parked
);
  int   ign_q  = 0;
  int   wait_q = 0;
  int   load_q = 0;
  logic run_q  = 1'b0;
  logic stby_q = 1'b0;

  initial begin
    o_cmd_ready = 1'b0;
    o_in_reset  = 1'b1;
    o_parked    = 1'b0;
  end

  always @(posedge i_clk) begin
    if (!i_pins.sense) ign_q <= 0;
    else if (ign_q < IGNORE_CYC) ign_q <= ign_q + 1;
  end

  // supply-good heard only after the ignore window
  always @(posedge i_clk) begin
    if (!i_pins.sense) o_in_reset <= 1'b1;
    else if (ign_q >= IGNORE_CYC) o_in_reset <= !i_pins.supply_good;
  end

  // slow on purpose, so the host must hold the command several cycles
  always @(posedge i_clk) begin
    wait_q <= (i_cmd.valid && !o_cmd_ready) ? wait_q + 1 : 0;
    o_cmd_ready <= i_cmd.valid && !o_cmd_ready && wait_q >= 5 &&
                   i_cmd.mode == pss_pkg::MODE_STANDBY;
  end

  // memory loads first, then the park step
  always @(posedge i_clk) begin
    if (ign_q == 1) begin
      run_q    <= 1'b0;
      stby_q   <= 1'b0;
      load_q   <= 0;
      o_parked <= 1'b0;
    end else begin
      if (!o_in_reset) run_q <= 1'b1;
      if (o_cmd_ready) stby_q <= 1'b1;
      if (run_q && (stby_q || o_in_reset) && load_q < LOADS)
        load_q <= load_q + 1;
      if (load_q == LOADS) o_parked <= 1'b1;
    end
  end
endmodule // pss_dev_model

// *** testbench/pss_host_ctrl_tb_top.sv ***
// self-checking bench for the supervisor host against a device model
`timescale 1ns/1ns
module pss_host_ctrl_tb_top;
  localparam int IGN     = 200;
  localparam int MIN_LOW = 20;
  localparam int HOLD    = 20;
  localparam int EXT     = 50;
  localparam int STBY    = 100;

  logic                  i_clk        = 1'b0;
  logic                  i_srst       = 1'b1;
  logic                  rails_ok     = 1'b0;
  logic                  v18_on       = 1'b0;
  logic                  power_fail   = 1'b0;
  logic                  shutdown_req = 1'b0;
  logic                  cmd_ready;
  logic                  in_reset;
  logic                  parked;
  logic                  hold;
  logic                  off_ok;
  logic                  overrun;
  pss_pkg::pss_pins_type pins;
  pss_pkg::pss_cmd_type  cmd;
  logic [5:0]            obs;
  int                    n_mismatch   = 0;
  int                    total_checks = 0;
  time                   t_fall       = 0;
  time                   t_rise       = 0;

  always #20 i_clk = ~i_clk;
  assign obs = {cmd.valid, overrun, off_ok, hold,
                pins.supply_good, pins.sense};

  pss_host_ctrl #(
    .SENSE_IGNORE_CYC (IGN),
    .PG_MAX_LOW_CYC   (400),
    .SENSE_MIN_LOW_CYC(MIN_LOW),
    .LOW_SUM_MAX_CYC  (420),
    .SENSE_HOLD_CYC   (HOLD),
    .EXT_HOLD_CYC     (EXT),
    .STANDBY_CYC      (STBY)
  ) pss_host_ctrl_inst (
    .i_clk(i_clk), .i_srst(i_srst), .i_rails_ok(rails_ok),
    .i_v18_on(v18_on), .i_power_fail(power_fail),
    .i_shutdown_req(shutdown_req), .i_cmd_ready(cmd_ready),
    .o_pins(pins), .o_cmd(cmd), .o_hold_supplies(hold),
    .o_power_off_ok(off_ok), .o_low_overrun(overrun)
  );

  pss_dev_model #(.IGNORE_CYC(IGN), .LOADS(8)) pss_dev_model_inst (
    .i_clk(i_clk), .i_pins(pins), .i_cmd(cmd), .o_cmd_ready(cmd_ready),
    .o_in_reset(in_reset), .o_parked(parked)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  // a wait that runs out is itself a mismatch
  task automatic wait_bit(input int idx, input logic val, input int maxc,
                          output int n);
    n = 0;
    while (obs[idx] !== val && n < maxc) begin
      @(negedge i_clk);
      n++;
    end
    check(32'(n < maxc), 32'h1);
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic t_reset();
    repeat (4) @(negedge i_clk);
    check(32'(obs), 32'h4);
    i_srst = 1'b0;
  endtask

  task automatic t_powerup();
    int n;
    rails_ok = 1'b0;
    repeat (30) @(negedge i_clk);
    check(32'(pins.sense), 32'h0);
    rails_ok = 1'b1;
    wait_bit(0, 1'b1, 40, n);
    t_rise = $time;
    if (t_fall != 0)
      check(32'((t_rise - t_fall) / 40 >= MIN_LOW), 32'h1);
    shutdown_req = 1'b1;
    @(negedge i_clk);
    shutdown_req = 1'b0;
    @(negedge i_clk);
    check(32'(cmd.valid), 32'h0);
    wait_bit(1, 1'b1, IGN + 20, n);
    check(32'(n + 2 >= IGN), 32'h1);
    repeat (4) @(negedge i_clk);
    check(32'(in_reset), 32'h0);
  endtask

  task automatic t_standby();
    int n1;
    int n2;
    shutdown_req = 1'b1;
    @(negedge i_clk);
    shutdown_req = 1'b0;
    wait_bit(5, 1'b1, 3, n1);
    check(32'(cmd), 32'h101);
    wait_bit(5, 1'b0, 20, n1);
    check(32'(pins.supply_good), 32'h1);
    wait_bit(1, 1'b0, STBY + 20, n2);
    check(32'(n1 + n2 + 1 >= STBY), 32'h1);
    wait_bit(0, 1'b0, HOLD + 5, n1);
    t_fall = $time;
    check(32'(n1 >= HOLD), 32'h1);
    wait_bit(3, 1'b1, EXT + 5, n2);
    check(32'({hold, parked}), 32'h1);
  endtask

  task automatic t_loss();
    int n1;
    int n2;
    power_fail = 1'b1;
    wait_bit(1, 1'b0, 6, n1);
    wait_bit(0, 1'b0, HOLD + 5, n1);
    check(32'(n1 >= HOLD), 32'h1);
    wait_bit(3, 1'b1, EXT + 5, n2);
    check(32'(n1 + n2 >= EXT), 32'h1);
    check(32'({hold, parked}), 32'h1);
    // long low time with 1.8 V off carries no limit
    repeat (500) @(negedge i_clk);
    check(32'({pins.supply_good, overrun}), 32'h0);
    v18_on = 1'b1;
    wait_bit(4, 1'b1, 500, n1);
    check(32'(overrun), 32'h1);
  endtask

  initial begin
    t_reset();
    t_powerup();
    t_standby();
    t_powerup();
    t_loss();
    conclude();
  end

  initial begin
    #(40 * 6000);
    n_mismatch++;
    conclude();
  end
endmodule // pss_host_ctrl_tb_top
